/* rtl/ctfp_timing.sv */
// Conversion scheduler, one-shot trigger and fan PWM timing with APB
//
// Notes on behaviour
// - Rate codes 0 to 9 repeat conversions at 0.05 to 26 Hz.
// - Rate codes 10 to 15 schedule like code 9, 26 Hz, but read back as written.
// - Bits 7:4 of the rate register are not stored and read as zero.
// - In standby each one-shot write runs one full two-channel cycle.
// - The one-shot register is write-only and its data is ignored.
// - The period and duty law applies only outside high-res mode.
// - Low-res period is 2N ticks of 360 kHz or 1.4 kHz, high duty[5:0] ticks.
// - High-res mode needs enable set, select clear, N of 0x08.
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ctfp_timing #(
    parameter ctfp_pkg::ctfp_period_arr_t CONV_PERIOD_CYC =
        ctfp_pkg::CONV_CYC_DEF,
    parameter int unsigned PWM_SLOW_DIV = ctfp_pkg::PWM_SLOW_DIV_DEF,
    parameter int unsigned CONV_CH_CYC  = ctfp_pkg::CONV_CH_CYC_DEF,
    parameter logic [7:0]  MAKER_ID     = ctfp_pkg::MAKER_ID_DEF,
    parameter logic [7:0]  REV_ID       = ctfp_pkg::REV_ID_DEF
) (
    input  wire logic                        mclk_in,
    input  wire logic                        rst_n_in,
    input  wire logic                        ce_in,
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [ctfp_pkg::APB_AW-1:0] paddr_in,
    input  wire logic [31:0]                 pwdata_in,
    output var  logic [31:0]                 prdata_out,
    output var  logic                        pready_out,
    output var  logic                        pslverr_out,
    output var  ctfp_pkg::ctfp_conv_t        conv_out,
    output var  logic                        pwm_out
);
    import ctfp_pkg::*;

    ctfp_ctrl_t       ctrl_reg;
    ctfp_conv_state_t state_reg;
    logic [7:0]       idx;
    logic             aligned;
    logic             cap_reg;
    logic [7:0]       rd_data;
    logic             rd_err;
    logic [7:0]       prdata_reg;
    logic             pslverr_reg;
    logic             xfer_done;
    logic             wr_en;
    logic             oneshot_wr;
    logic [3:0]       eff_code;
    logic [31:0]      period_sel;
    logic [31:0]      rate_cnt_reg;
    logic             rate_hit;
    logic             due_reg;
    logic             shot_reg;
    logic             conv_go;
    logic [31:0]      ch_cnt_reg;
    logic             ch_end;
    logic             start_reg;
    logic             hr_mode;
    logic [4:0]       eff_n;
    logic [7:0]       pwm_period;
    logic [7:0]       pwm_high;
    logic [31:0]      div_sel;
    logic [31:0]      pre_cnt_reg;
    logic             pwm_tick;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign idx     = paddr_in[9:2];
    assign aligned = (paddr_in[1:0] == 2'b00) && (paddr_in[11:10] == 2'b00);

    // Read data and error are caught from a register in the cycle before
    // the answer, so a clock-enable gap just adds wait states
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cap_reg <= 1'b0;
        end else if (ce_in) begin
            if (psel_in && penable_in && cap_reg) begin
                cap_reg <= 1'b0;
            end else begin
                cap_reg <= psel_in;
            end
        end
    end

    assign pready_out = cap_reg && ce_in;
    assign xfer_done  = psel_in && penable_in && pready_out;
    assign wr_en      = xfer_done && pwrite_in && !pslverr_reg;
    // Any value may be written: only the address matters
    assign oneshot_wr = wr_en && (idx == IDX_ONE_SHOT);

    always_comb begin
        rd_data = 8'h00;
        rd_err  = 1'b0;
        if (!aligned) begin
            rd_err = 1'b1;
        end else begin
            case (idx)
                IDX_STATUS:    rd_data[BIT_BUSY] = conv_out.busy;
                IDX_CONFIG:    rd_data[BIT_STANDBY] = ctrl_reg.standby;
                IDX_CONV_RATE: rd_data = {4'h0, ctrl_reg.rate_code};
                IDX_ONE_SHOT:  rd_data = 8'h00;
                IDX_ENH_CFG:   rd_data[BIT_HR_EN] = ctrl_reg.hr_en;
                IDX_PWM_CFG:   rd_data[BIT_CLK_SEL] = ctrl_reg.clk_sel;
                IDX_PWM_DUTY:  rd_data = ctrl_reg.pwm_duty;
                IDX_PWM_FREQ:  rd_data = {3'h0, ctrl_reg.pwm_freq};
                IDX_MAKER_ID:  rd_data = MAKER_ID;
                IDX_REV_ID:    rd_data = REV_ID;
                default:       rd_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_reg  <= 8'h00;
            pslverr_reg <= 1'b0;
        end else if (ce_in && psel_in && !cap_reg) begin
            prdata_reg  <= rd_data;
            pslverr_reg <= rd_err;
        end
    end

    assign prdata_out  = {24'h000000, prdata_reg};
    assign pslverr_out = pslverr_reg && pready_out;

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Writes to read-only indices are accepted and dropped
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= CTRL_RST;
        end else if (ce_in && wr_en) begin
            case (idx)
                IDX_CONFIG:    ctrl_reg.standby <= pwdata_in[BIT_STANDBY];
                IDX_CONV_RATE: ctrl_reg.rate_code <= pwdata_in[3:0];
                IDX_ENH_CFG:   ctrl_reg.hr_en <= pwdata_in[BIT_HR_EN];
                IDX_PWM_CFG:   ctrl_reg.clk_sel <= pwdata_in[BIT_CLK_SEL];
                IDX_PWM_DUTY:  ctrl_reg.pwm_duty <= pwdata_in[7:0];
                IDX_PWM_FREQ:  ctrl_reg.pwm_freq <= pwdata_in[4:0];
                default:       ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // ****************************************************************
    // Conversion scheduler
    // ****************************************************************
    assign eff_code = (ctrl_reg.rate_code > RATE_MAX_CODE) ?
                      RATE_MAX_CODE : ctrl_reg.rate_code;
    assign period_sel = CONV_PERIOD_CYC[eff_code];
    // Compare with >= so a faster rate written mid-count acts at once
    assign rate_hit = !ctrl_reg.standby &&
                      (rate_cnt_reg >= 32'(period_sel - 32'd1));

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rate_cnt_reg <= 32'h00000000;
        end else if (ce_in) begin
            if (ctrl_reg.standby || rate_hit) begin
                rate_cnt_reg <= 32'h00000000;
            end else begin
                rate_cnt_reg <= 32'(rate_cnt_reg + 32'd1);
            end
        end
    end

    // A tick that lands while a cycle is still running waits for idle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            due_reg <= 1'b0;
        end else if (ce_in) begin
            if (rate_hit) begin
                due_reg <= 1'b1;
            end else if (conv_go || ctrl_reg.standby) begin
                due_reg <= 1'b0;
            end
        end
    end

    // Set wins over the clear; running-mode writes leave the schedule be
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shot_reg <= 1'b0;
        end else if (ce_in) begin
            if (oneshot_wr && ctrl_reg.standby) begin
                shot_reg <= 1'b1;
            end else if (conv_go) begin
                shot_reg <= 1'b0;
            end
        end
    end

    assign conv_go = (state_reg == CV_IDLE) && (due_reg || shot_reg);
    assign ch_end  = (ch_cnt_reg >= 32'(CONV_CH_CYC - 1));

    // Local channel, then remote channel, one cycle in done
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg  <= CV_IDLE;
            ch_cnt_reg <= 32'h00000000;
        end else if (ce_in) begin
            case (state_reg)
                CV_IDLE: begin
                    ch_cnt_reg <= 32'h00000000;
                    if (conv_go) begin
                        state_reg <= CV_LOCAL;
                    end
                end
                CV_LOCAL: begin
                    if (ch_end) begin
                        ch_cnt_reg <= 32'h00000000;
                        state_reg  <= CV_REMOTE;
                    end else begin
                        ch_cnt_reg <= 32'(ch_cnt_reg + 32'd1);
                    end
                end
                CV_REMOTE: begin
                    if (ch_end) begin
                        ch_cnt_reg <= 32'h00000000;
                        state_reg  <= CV_DONE;
                    end else begin
                        ch_cnt_reg <= 32'(ch_cnt_reg + 32'd1);
                    end
                end
                CV_DONE: state_reg <= CV_IDLE;
                default: state_reg <= CV_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_reg <= 1'b0;
        end else if (ce_in) begin
            start_reg <= conv_go;
        end
    end

    // One driver for the whole carrier keeps strict tools content
    assign conv_out = '{busy: (state_reg != CV_IDLE), start: start_reg,
                        remote: (state_reg == CV_REMOTE)};

    // ****************************************************************
    // Fan PWM timing
    // ****************************************************************
    assign hr_mode = ctrl_reg.hr_en && !ctrl_reg.clk_sel &&
                     (ctrl_reg.pwm_freq == PWM_HR_FREQ);
    assign eff_n = (ctrl_reg.pwm_freq == 5'h00) ?
                   5'h01 : ctrl_reg.pwm_freq;
    // Low-res law is bypassed in high-res mode
    assign pwm_period = hr_mode ? PWM_HR_STEPS :
                        {2'b00, eff_n, 1'b0};
    assign pwm_high = hr_mode ? ctrl_reg.pwm_duty :
                      {2'b00, ctrl_reg.pwm_duty[5:0]};
    assign div_sel = hr_mode ? 32'(PWM_HR_DIV) :
                     (ctrl_reg.clk_sel ? 32'(PWM_SLOW_DIV) :
                      32'(PWM_FAST_DIV));
    assign pwm_tick = (pre_cnt_reg >= 32'(div_sel - 32'd1));

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_cnt_reg <= 32'h00000000;
        end else if (ce_in) begin
            if (pwm_tick) begin
                pre_cnt_reg <= 32'h00000000;
            end else begin
                pre_cnt_reg <= 32'(pre_cnt_reg + 32'd1);
            end
        end
    end

    ctfp_pwm_gen u_pwm (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .ce_in     (ce_in),
        .tick_in   (pwm_tick),
        .period_in (pwm_period),
        .high_in   (pwm_high),
        .pwm_out   (pwm_out)
    );

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_RATE_UPPER_ZERO: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (ce_in && psel_in && !cap_reg && !pwrite_in && aligned &&
         idx == IDX_CONV_RATE) |=> (prdata_out[31:4] == 28'h0000000))
        else $error("rate register upper bits not zero");

    AST_RATE_MAP: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (rate_hit && ctrl_reg.rate_code <= RATE_MAX_CODE) |->
        (rate_cnt_reg == CONV_PERIOD_CYC[ctrl_reg.rate_code] - 1))
        else $error("conversion period does not match rate code");

    AST_RATE_CLAMP: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (rate_hit && ctrl_reg.rate_code > RATE_MAX_CODE) |->
        (rate_cnt_reg == CONV_PERIOD_CYC[9] - 1))
        else $error("high rate code not treated as fastest");

    AST_SHOT_START: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (ce_in && oneshot_wr && ctrl_reg.standby &&
         state_reg == CV_IDLE && !conv_go) |=> (shot_reg && conv_go) ##1
         (conv_out.start || !$past(ce_in)))
        else $error("one-shot in standby did not start a cycle");

    AST_CYCLE_SHAPE: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (ce_in && state_reg == CV_LOCAL && ch_end) |=>
        (state_reg == CV_REMOTE && conv_out.busy && conv_out.remote))
        else $error("conversion cycle skipped the remote channel");

    AST_RUN_SHOT_IGNORED: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (ce_in && oneshot_wr && !ctrl_reg.standby && !shot_reg) |=>
        (!shot_reg && rate_cnt_reg != 32'h00000000 || $past(rate_hit)))
        else $error("running-mode one-shot disturbed the schedule");

    AST_FREQ_ZERO: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (ctrl_reg.pwm_freq == 5'h00) |-> (pwm_period == 8'h02))
        else $error("frequency field zero not treated as one");

    AST_LR_PERIOD: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (!hr_mode && ctrl_reg.pwm_freq != 5'h00) |->
        (pwm_period == 8'(2 * ctrl_reg.pwm_freq) &&
         pwm_high == {2'b00, ctrl_reg.pwm_duty[5:0]}))
        else $error("low-res period or duty wrong");

    AST_HR_SELECT: assert property (
        @(posedge mclk_in) disable iff (!rst_n_in)
        (pwm_period == 8'hFF) |->
        (ctrl_reg.hr_en && !ctrl_reg.clk_sel && ctrl_reg.pwm_freq == 5'h08
         && pwm_high == ctrl_reg.pwm_duty && div_sel == 32'(PWM_HR_DIV)))
        else $error("high-res timing active without its conditions");

endmodule : ctfp_timing
`default_nettype wire

/* pkg/ctfp_pkg.sv */
// Package: register map, field layout and timing constants for the block
package ctfp_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_STATUS    = 8'h02;
    localparam logic [7:0] IDX_CONFIG    = 8'h03;
    localparam logic [7:0] IDX_CONV_RATE = 8'h04;
    localparam logic [7:0] IDX_ONE_SHOT  = 8'h0F;
    localparam logic [7:0] IDX_ENH_CFG   = 8'h45;
    localparam logic [7:0] IDX_PWM_CFG   = 8'h4A;
    localparam logic [7:0] IDX_PWM_DUTY  = 8'h4C;
    localparam logic [7:0] IDX_PWM_FREQ  = 8'h4D;
    localparam logic [7:0] IDX_MAKER_ID  = 8'hFE;
    localparam logic [7:0] IDX_REV_ID    = 8'hFF;

    // ****************************************************************
    // Field positions and widths
    // ****************************************************************
    localparam int unsigned APB_AW      = 12;
    localparam int unsigned BIT_BUSY    = 7;
    localparam int unsigned BIT_STANDBY = 6;
    localparam int unsigned BIT_HR_EN   = 4;
    localparam int unsigned BIT_CLK_SEL = 3;
    localparam int unsigned NUM_RATES   = 10;
    localparam logic [3:0]  RATE_MAX_CODE = 4'h9;
    localparam logic [4:0]  PWM_HR_FREQ   = 5'h08;
    localparam logic [7:0]  PWM_HR_STEPS  = 8'hFF;

    // ****************************************************************
    // Identity defaults (values are arbitrary)
    // ****************************************************************
    localparam logic [7:0] MAKER_ID_DEF = 8'h5A;
    localparam logic [7:0] REV_ID_DEF   = 8'hA3;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint unsigned CLK_HZ      = 64'd25_000_000;
    localparam longint unsigned PWM_FAST_HZ = 64'd360_000;
    localparam longint unsigned PWM_SLOW_HZ = 64'd1_400;
    localparam longint unsigned PWM_HR_HZ   = 64'd22_500;
    localparam int unsigned PWM_FAST_DIV = int'(CLK_HZ / PWM_FAST_HZ);
    localparam int unsigned PWM_SLOW_DIV_DEF = int'(CLK_HZ / PWM_SLOW_HZ);
    localparam int unsigned PWM_HR_DIV =
        int'(CLK_HZ / (PWM_HR_HZ * 64'd255));
    localparam int unsigned CONV_CH_CYC_DEF = 256;

    typedef int unsigned ctfp_period_arr_t [0:NUM_RATES-1];

    // Conversion repetition rates in millihertz, one per code
    localparam ctfp_period_arr_t RATE_MHZ = '{
        50, 100, 204, 406, 813, 1625, 3250, 6500, 13000, 26000};

    function automatic ctfp_period_arr_t ctfp_conv_cycles();
        ctfp_period_arr_t r;
        for (int i = 0; i < NUM_RATES; i++) begin
            r[i] = int'((CLK_HZ * 64'd1000) / longint'(RATE_MHZ[i]));
        end
        return r;
    endfunction : ctfp_conv_cycles

    localparam ctfp_period_arr_t CONV_CYC_DEF = ctfp_conv_cycles();

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic       standby;
        logic [3:0] rate_code;
        logic       hr_en;
        logic       clk_sel;
        logic [4:0] pwm_freq;
        logic [7:0] pwm_duty;
    } ctfp_ctrl_t;

    localparam ctfp_ctrl_t CTRL_RST = '{standby: 1'b0, rate_code: 4'h8,
        hr_en: 1'b0, clk_sel: 1'b0, pwm_freq: 5'h08, pwm_duty: 8'h00};

    typedef struct packed {
        logic busy;
        logic start;
        logic remote;
    } ctfp_conv_t;

    typedef enum logic [1:0] {
        CV_IDLE   = 2'b00,
        CV_LOCAL  = 2'b01,
        CV_REMOTE = 2'b11,
        CV_DONE   = 2'b10
    } ctfp_conv_state_t;

endpackage : ctfp_pkg

/* rtl/ctfp_pwm_gen.sv */
// PWM waveform generator: period and high count in ticks
`timescale 1ns/100ps
`default_nettype none
module ctfp_pwm_gen (
    input  wire logic       mclk_in,
    input  wire logic       rst_n_in,
    input  wire logic       ce_in,
    input  wire logic       tick_in,
    input  wire logic [7:0] period_in,
    input  wire logic [7:0] high_in,
    output var  logic       pwm_out
);
    import ctfp_pkg::*;

    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       pwm_reg;

    // ****************************************************************
    // Tick counter
    // ****************************************************************
    // Wrap on >= so a shrunken period never runs the count away
    always_comb begin
        if (cnt_reg >= 8'(period_in - 8'h01)) begin
            cnt_next = 8'h00;
        end else begin
            cnt_next = 8'(cnt_reg + 8'h01);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= 8'h00;
        end else if (ce_in && tick_in) begin
            cnt_reg <= cnt_next;
        end
    end

    // ****************************************************************
    // Output
    // ****************************************************************
    // High count equal to the period gives a steady high level
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwm_reg <= 1'b0;
        end else if (ce_in) begin
            pwm_reg <= (cnt_reg < high_in);
        end
    end

    assign pwm_out = pwm_reg;

endmodule : ctfp_pwm_gen
`default_nettype wire

/* tb/ctfp_fan_model.sv */
// Fan model: measures high time and period of the PWM drive in clocks
`timescale 1ns/100ps
`default_nettype none
module ctfp_fan_model (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        pwm_in,
    output var  int unsigned high_out,
    output var  int unsigned period_out
);
    int unsigned cnt_reg;
    logic        last_reg;
    // A steady level gives no edges, so old figures stay until it moves
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg    <= 0;
            last_reg   <= 1'b0;
            high_out   <= 0;
            period_out <= 0;
        end else begin
            last_reg <= pwm_in;
            cnt_reg  <= cnt_reg + 1;
            if (pwm_in && !last_reg) begin
                period_out <= cnt_reg;
                cnt_reg    <= 1;
            end
            if (!pwm_in && last_reg) begin
                high_out <= cnt_reg;
            end
        end
    end
endmodule : ctfp_fan_model
`default_nettype wire

/* tb/tb_top.sv */
// Testbench for the conversion scheduler and fan PWM timing block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ctfp_pkg::*;
    localparam ctfp_period_arr_t CPER = '{200, 180, 160, 140, 120, 100,
        80, 60, 40, 20};
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, pwm, err, ce = 1'b1;
    ctfp_conv_t conv;
    int unsigned hi, per;
    int mismatches = 0, n_compared = 0, ns, nb, nr, g, b_s, b_b, b_r;
    // Short counts keep the run brief; expectations use the same values
    ctfp_timing #(.CONV_PERIOD_CYC(CPER), .PWM_SLOW_DIV(8),
        .CONV_CH_CYC(4)) uut (.mclk_in(mclk), .rst_n_in(rst_n),
        .ce_in(ce), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .conv_out(conv),
        .pwm_out(pwm));
    ctfp_fan_model fan (.mclk_in(mclk), .rst_n_in(rst_n), .pwm_in(pwm),
        .high_out(hi), .period_out(per));
    initial begin
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        ns += (conv.start === 1'b1);
        nb += (conv.busy === 1'b1);
        nr += (conv.remote === 1'b1);
    end
    task automatic final_report();
        $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s exp %0h got %0h", name, exp, got);
        end
    endtask : chk
    // Holds the request until pready is seen high at a rising edge
    task automatic apb(logic wr, logic [7:0] idx, logic [7:0] wd);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'hC3C3C3, wd};
        @(posedge mclk);
        pen <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic gap(output int n);
        int k;
        k = 0;
        n = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (conv.start !== 1'b1 && k < 1000);
        do begin
            @(posedge mclk);
            n++;
        end while (conv.start !== 1'b1 && n < 1000);
    endtask : gap
    initial begin
        #(40ns * 40000);
        mismatches++;
        final_report();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int pw[4][6] = '{'{0, 0, 0, 1, 138, 69}, '{0, 1, 3, 8'h45, 48, 40},
            '{1, 1, 8, 3, 128, 24}, '{1, 0, 8, 8'h80, 1020, 512}};
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        apb(0, IDX_CONV_RATE, 8'h00);
        chk("rate reset", 32'h8, rd);
        apb(0, IDX_MAKER_ID, 8'h00);
        chk("maker", {24'h0, MAKER_ID_DEF}, rd);
        apb(0, IDX_REV_ID, 8'h00);
        chk("rev", {24'h0, REV_ID_DEF}, rd);
        for (int i = 0; i < 16; i++) begin
            apb(1, IDX_CONV_RATE, {~i[3:0], i[3:0]});
            apb(0, IDX_CONV_RATE, 8'h00);
            chk("rate rd", {28'h0, i[3:0]}, rd);
            gap(g);
            chk("conv gap", i > 9 ? CPER[9] : CPER[i], g);
        end
        apb(1, IDX_CONFIG, 8'h40);
        repeat (20) @(posedge mclk);
        b_s = ns;
        repeat (300) @(posedge mclk);
        chk("standby starts", 0, ns - b_s);
        for (int d = 0; d < 2; d++) begin
            // Snapshots instead of clearing: the counters have one driver
            b_s = ns;
            b_b = nb;
            b_r = nr;
            apb(1, IDX_ONE_SHOT, d ? 8'hA5 : 8'h00);
            repeat (30) @(posedge mclk);
            chk("shot starts", 1, ns - b_s);
            chk("shot busy", 9, nb - b_b);
            chk("shot remote", 4, nr - b_r);
        end
        apb(0, IDX_ONE_SHOT, 8'h00);
        chk("shot rd", 32'h0, rd);
        chk("shot err", 0, err);
        apb(0, 8'h10, 8'h00);
        chk("unmapped err", 1, err);
        apb(1, IDX_CONFIG, 8'h00);
        gap(g);
        apb(1, IDX_ONE_SHOT, 8'h3C);
        gap(g);
        chk("running gap", CPER[9], g);
        // Clock enable low must freeze the schedule: no start may appear
        @(posedge mclk);
        b_s = ns;
        ce <= 1'b0;
        repeat (50) @(posedge mclk);
        chk("ce freeze", 0, ns - b_s);
        ce <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            apb(1, IDX_ENH_CFG, pw[r][0] ? 8'h10 : 8'h00);
            apb(1, IDX_PWM_CFG, pw[r][1] ? 8'h08 : 8'h00);
            apb(1, IDX_PWM_FREQ, 8'(pw[r][2]));
            apb(1, IDX_PWM_DUTY, 8'(pw[r][3]));
            repeat (3 * pw[r][4] + 50) @(posedge mclk);
            chk("pwm period", pw[r][4], per);
            chk("pwm high", pw[r][5], hi);
        end
        final_report();
    end
endmodule : tb_top
`default_nettype wire
